// file: core/lus_pkg.sv
package lus_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus geometry
   localparam int          ADDR_W      = 12;
   localparam int          DATA_W      = 32;
   localparam int          IDX_W       = 10;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_TX_PEAK_CTRL = 10'h021;
   localparam logic [IDX_W-1:0] IDX_RX_PEAK_CTRL = 10'h027;
   localparam logic [IDX_W-1:0] IDX_CNT_CTRL     = 10'h031;
   localparam logic [IDX_W-1:0] IDX_TERM_SEL     = 10'h032;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN_LINE  = 10'h033;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN_ERR   = 10'h034;
   localparam logic [IDX_W-1:0] IDX_EDGE_SEL     = 10'h035;
   localparam logic [IDX_W-1:0] IDX_LINE_COND    = 10'h036;
   localparam logic [IDX_W-1:0] IDX_EQ_GAIN      = 10'h037;
   localparam logic [IDX_W-1:0] IDX_TX_SPREAD    = 10'h038;
   localparam logic [IDX_W-1:0] IDX_RX_SPREAD    = 10'h039;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT_LINE = 10'h03A;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT_ERR = 10'h03B;
   localparam logic [IDX_W-1:0] IDX_CNT_HIGH     = 10'h03C;
   localparam logic [IDX_W-1:0] IDX_CNT_LOW      = 10'h03D;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLR_LINE = 10'h0F0;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLR_ERR  = 10'h0F1;

   ////////////////////////////////////////////////////////////////////////////
   // field positions and masks
   localparam int         CNT_TRIGGER_BIT = 0;
   localparam int         CNT_MODE_BIT    = 1;
   localparam int         PEAK_MODE_BIT   = 5;
   localparam int         DRIVER_FAIL_BIT = 2;
   localparam int         SIG_ABSENT_BIT  = 0;
   localparam int         TEMPLATE_BIT    = 6;
   localparam int         TX_SLIP_BIT     = 5;
   localparam int         RX_SLIP_BIT     = 4;
   localparam int         ZERO_RUN_BIT    = 2;
   localparam int         CODE_VIOL_BIT   = 1;
   localparam int         CNT_OVF_BIT     = 0;
   localparam int         TX_TERM_LSB     = 3;
   localparam int         RX_TERM_LSB     = 0;
   localparam int         GAIN_W          = 5;
   localparam int         SPREAD_W        = 7;
   localparam int         COUNT_W         = 16;
   localparam logic [7:0] MASK_CNT_CTRL   = 8'h03;
   localparam logic [7:0] MASK_TERM       = 8'h3F;
   localparam logic [7:0] MASK_LINE       = 8'h05;
   localparam logic [7:0] MASK_ERR        = 8'h77;
   localparam logic [7:0] RESET_TERM      = 8'h07;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam longint CLK_PERIOD_NS    = 20;
   localparam longint REPORT_PERIOD_MS = 1000;
   localparam longint REPORT_CYCLES    = (REPORT_PERIOD_MS * 64'd1000000) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic driverFail;
      logic signalAbsent;
   } lus_line_t;

   typedef struct packed {
      logic templateSum;
      logic txFifoSlip;
      logic rxFifoSlip;
      logic zeroRun;
      logic codeViolation;
      logic counterOverflow;
   } lus_evt_t;

   // bypass set: external network, ohmSel 0..3 = 75/120/100/110 ohm
   typedef struct packed {
      logic       bypass;
      logic [1:0] ohmSel;
   } lus_term_t;

endpackage

// file: core/lus_regs.sv
`timescale 1ns/10ps
// Functional notes
// - snapshot trigger acts only in manual mode
// - trigger rising edge copies counter to readback
// - transmit impedance code; 1xx bypasses matching
// - receive impedance decodes the same way
// - line event enables gate interrupt output
// - six error enables gate interrupt output
// - edge select: rising only, or both edges
// - driver failure flag shows live condition
// - signal absent flag shows live condition
// - five bit equalizer gain code readback
// - spread: current distance or peak-to-peak
// - writing one clears the transmit spread
// - auto mode copies counter every second
// - status bits stay until written one
module lus_regs
   import lus_pkg::*;
#(
   parameter int REPORT_PERIOD_CYCLES = int'(REPORT_CYCLES)
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // line datapath status
   input  wire lus_line_t         lineIn,
   input  wire lus_evt_t          evtIn,
   input  wire logic [COUNT_W-1:0] excessZerosCount,
   input  wire logic [GAIN_W-1:0]  equalizerGainCode,
   input  wire logic [SPREAD_W-1:0] txPointerDistance,
   input  wire logic [SPREAD_W-1:0] rxPointerDistance,
   // line control and interrupt
   output lus_term_t              txTerm,
   output lus_term_t              rxTerm,
   output logic                   irq
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic                awHeld;
   logic                wHeld;
   logic [IDX_W-1:0]    awIdx;
   logic [7:0]          wByte;
   logic                wLane0;
   logic                awHs;
   logic                wHs;
   logic                arHs;
   logic                wrDo;
   logic                wrEn;
   logic                next_awHeld;
   logic                next_wHeld;
   logic                next_bvalid;
   logic                wrHit;
   logic                rdHit;
   logic [7:0]          rdByte;
   logic [IDX_W-1:0]    arIdx;

   logic [7:0]          cntCtrl;
   logic [7:0]          termSel;
   logic [7:0]          irqEnLine;
   logic [7:0]          irqEnErr;
   logic [7:0]          edgeSel;
   logic [7:0]          irqStatLine;
   logic [7:0]          irqStatErr;
   logic [7:0]          setLine;
   logic [7:0]          setErr;
   logic [7:0]          clrLine;
   logic [7:0]          clrErr;
   lus_line_t           lineFlag;
   logic [GAIN_W-1:0]   gainCode;
   logic [COUNT_W-1:0]  counterSnap;
   logic                triggerPrev;
   logic                snapNow;
   logic [31:0]         secCount;
   logic                secTick;
   logic                dfChange;
   logic                losChange;

   logic [SPREAD_W-1:0] spreadDist [2];
   logic [SPREAD_W-1:0] spreadVal  [2];
   logic [SPREAD_W-1:0] spreadMin  [2];
   logic [SPREAD_W-1:0] spreadMax  [2];
   logic                peakMode   [2];
   logic                spreadClr  [2];
   logic                spreadRead [2];

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel: address and data taken in either order
   assign awHs   = s_axi_awvalid & s_axi_awready;
   assign wHs    = s_axi_wvalid & s_axi_wready;
   assign arHs   = s_axi_arvalid & s_axi_arready;
   assign wrDo   = awHeld & wHeld & ~s_axi_bvalid;
   assign wrEn   = wrDo & wrHit & wLane0;
   assign arIdx  = s_axi_araddr[ADDR_W-1:2];

   assign next_awHeld = (awHeld | awHs) & ~wrDo;
   assign next_wHeld  = (wHeld | wHs) & ~wrDo;
   assign next_bvalid = wrDo | (s_axi_bvalid & ~s_axi_bready);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
         awIdx         <= '0;
         wByte         <= 8'h00;
         wLane0        <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         awHeld        <= next_awHeld;
         wHeld         <= next_wHeld;
         s_axi_awready <= ~next_awHeld & ~next_bvalid;
         s_axi_wready  <= ~next_wHeld & ~next_bvalid;
         s_axi_bvalid  <= next_bvalid;
         if (awHs) begin
            awIdx <= s_axi_awaddr[ADDR_W-1:2];
         end
         if (wHs) begin
            wByte  <= s_axi_wdata[7:0];
            wLane0 <= s_axi_wstrb[0];
         end
         if (wrDo) begin
            s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // only low lane carries data; upper lanes are accepted and dropped
   always_comb begin
      unique case (awIdx)
         IDX_TX_PEAK_CTRL, IDX_RX_PEAK_CTRL, IDX_CNT_CTRL, IDX_TERM_SEL,
         IDX_IRQ_EN_LINE, IDX_IRQ_EN_ERR, IDX_EDGE_SEL, IDX_LINE_COND,
         IDX_EQ_GAIN, IDX_TX_SPREAD, IDX_RX_SPREAD, IDX_IRQ_STAT_LINE,
         IDX_IRQ_STAT_ERR, IDX_CNT_HIGH, IDX_CNT_LOW, IDX_IRQ_CLR_LINE,
         IDX_IRQ_CLR_ERR: wrHit = 1'b1;
         default:         wrHit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel
   always_comb begin
      rdHit  = 1'b1;
      rdByte = 8'h00;
      unique case (arIdx)
         IDX_TX_PEAK_CTRL:  rdByte[PEAK_MODE_BIT] = peakMode[0];
         IDX_RX_PEAK_CTRL:  rdByte[PEAK_MODE_BIT] = peakMode[1];
         IDX_CNT_CTRL:      rdByte = cntCtrl;
         IDX_TERM_SEL:      rdByte = termSel;
         IDX_IRQ_EN_LINE:   rdByte = irqEnLine;
         IDX_IRQ_EN_ERR:    rdByte = irqEnErr;
         IDX_EDGE_SEL:      rdByte = edgeSel;
         IDX_LINE_COND: begin
            rdByte[DRIVER_FAIL_BIT] = lineFlag.driverFail;
            rdByte[SIG_ABSENT_BIT]  = lineFlag.signalAbsent;
         end
         IDX_EQ_GAIN:       rdByte[GAIN_W-1:0] = gainCode;
         IDX_TX_SPREAD:     rdByte[SPREAD_W-1:0] = spreadVal[0];
         IDX_RX_SPREAD:     rdByte[SPREAD_W-1:0] = spreadVal[1];
         IDX_IRQ_STAT_LINE: rdByte = irqStatLine;
         IDX_IRQ_STAT_ERR:  rdByte = irqStatErr;
         IDX_CNT_HIGH:      rdByte = counterSnap[15:8];
         IDX_CNT_LOW:       rdByte = counterSnap[7:0];
         IDX_IRQ_CLR_LINE, IDX_IRQ_CLR_ERR: rdByte = 8'h00;
         default:           rdHit = 1'b0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~arHs & (~s_axi_rvalid | s_axi_rready);
         if (arHs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rdByte};
            s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cntCtrl     <= 8'h00;
         termSel     <= RESET_TERM;
         irqEnLine   <= 8'h00;
         irqEnErr    <= 8'h00;
         edgeSel     <= 8'h00;
         peakMode[0] <= 1'b0;
         peakMode[1] <= 1'b0;
      end else if (wrEn) begin
         unique case (awIdx)
            IDX_CNT_CTRL:     cntCtrl   <= wByte & MASK_CNT_CTRL;
            IDX_TERM_SEL:     termSel   <= wByte & MASK_TERM;
            IDX_IRQ_EN_LINE:  irqEnLine <= wByte & MASK_LINE;
            IDX_IRQ_EN_ERR:   irqEnErr  <= wByte & MASK_ERR;
            IDX_EDGE_SEL:     edgeSel   <= wByte & MASK_LINE;
            IDX_TX_PEAK_CTRL: peakMode[0] <= wByte[PEAK_MODE_BIT];
            IDX_RX_PEAK_CTRL: peakMode[1] <= wByte[PEAK_MODE_BIT];
            default: ;
         endcase
      end
   end

   // decoded termination straight from flops
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         txTerm <= '0;
         rxTerm <= '0;
      end else begin
         txTerm.bypass <= termSel[TX_TERM_LSB+2];
         txTerm.ohmSel <= termSel[TX_TERM_LSB+:2];
         rxTerm.bypass <= termSel[RX_TERM_LSB+2];
         rxTerm.ohmSel <= termSel[RX_TERM_LSB+:2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // line condition, gain and edge-selected events
   assign dfChange  = lineIn.driverFail ^ lineFlag.driverFail;
   assign losChange = lineIn.signalAbsent ^ lineFlag.signalAbsent;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         lineFlag <= '0;
         gainCode <= '0;
      end else begin
         lineFlag <= lineIn;
         gainCode <= equalizerGainCode;
      end
   end

   always_comb begin
      setLine = 8'h00;
      setLine[DRIVER_FAIL_BIT] = dfChange &
         (lineIn.driverFail | edgeSel[DRIVER_FAIL_BIT]);
      setLine[SIG_ABSENT_BIT] = losChange &
         (lineIn.signalAbsent | edgeSel[SIG_ABSENT_BIT]);
      setErr = 8'h00;
      setErr[TEMPLATE_BIT]  = evtIn.templateSum;
      setErr[TX_SLIP_BIT]   = evtIn.txFifoSlip;
      setErr[RX_SLIP_BIT]   = evtIn.rxFifoSlip;
      setErr[ZERO_RUN_BIT]  = evtIn.zeroRun;
      setErr[CODE_VIOL_BIT] = evtIn.codeViolation;
      setErr[CNT_OVF_BIT]   = evtIn.counterOverflow;
      clrLine = 8'h00;
      clrErr  = 8'h00;
      if (wrEn && (awIdx == IDX_IRQ_STAT_LINE || awIdx == IDX_IRQ_CLR_LINE)) begin
         clrLine = wByte;
      end
      if (wrEn && (awIdx == IDX_IRQ_STAT_ERR || awIdx == IDX_IRQ_CLR_ERR)) begin
         clrErr = wByte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky status; a set in the clearing cycle survives
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irqStatLine <= 8'h00;
         irqStatErr  <= 8'h00;
      end else begin
         irqStatLine <= ((irqStatLine & ~clrLine) | setLine) & MASK_LINE;
         irqStatErr  <= ((irqStatErr & ~clrErr) | setErr) & MASK_ERR;
      end
   end

   // one cycle behind status, keeps the pin glitch free
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatLine & irqEnLine)
              | |(irqStatErr & irqEnErr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // excess-zeros counter snapshot
   assign secTick = (secCount == 32'(REPORT_PERIOD_CYCLES - 1));
   // level held at 1 gives one copy only, software must rearm
   assign snapNow = cntCtrl[CNT_MODE_BIT]
                  ? secTick
                  : (cntCtrl[CNT_TRIGGER_BIT] & ~triggerPrev);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         secCount <= 32'h0000_0000;
      end else if (secTick) begin
         secCount <= 32'h0000_0000;
      end else begin
         secCount <= secCount + 32'h0000_0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         triggerPrev <= 1'b0;
         counterSnap <= '0;
      end else begin
         triggerPrev <= cntCtrl[CNT_TRIGGER_BIT];
         if (snapNow) begin
            counterSnap <= excessZerosCount;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // jitter fifo pointer spread, transmit then receive
   assign spreadDist[0] = txPointerDistance;
   assign spreadDist[1] = rxPointerDistance;
   assign spreadClr[0]  = wrEn & (awIdx == IDX_TX_SPREAD) & wByte[0];
   assign spreadClr[1]  = wrEn & (awIdx == IDX_RX_SPREAD) & wByte[0];
   assign spreadRead[0] = arHs & (arIdx == IDX_TX_SPREAD);
   assign spreadRead[1] = arHs & (arIdx == IDX_RX_SPREAD);

   for (genvar g = 0; g < 2; g++) begin : gSpread
      logic [SPREAD_W-1:0] hiNow;
      logic [SPREAD_W-1:0] loNow;
      assign hiNow = (spreadDist[g] > spreadMax[g]) ? spreadDist[g] : spreadMax[g];
      assign loNow = (spreadDist[g] < spreadMin[g]) ? spreadDist[g] : spreadMin[g];

      // peak window restarts on every read or clear of the value
      always_ff @(posedge mclk) begin
         if (sys_rst) begin
            spreadMin[g] <= '0;
            spreadMax[g] <= '0;
            spreadVal[g] <= '0;
         end else if (spreadClr[g]) begin
            spreadMin[g] <= spreadDist[g];
            spreadMax[g] <= spreadDist[g];
            spreadVal[g] <= '0;
         end else begin
            spreadMin[g] <= spreadRead[g] ? spreadDist[g] : loNow;
            spreadMax[g] <= spreadRead[g] ? spreadDist[g] : hiNow;
            spreadVal[g] <= peakMode[g] ? SPREAD_W'(hiNow - loNow)
                                        : spreadDist[g];
         end
      end
   end

endmodule

// file: verif/lus_host.sv
`timescale 1ns/10ps
module lus_host
   import lus_pkg::*;
(
   // clock
   input  wire logic              mclk,
   // axi4-lite master
   output logic [ADDR_W-1:0]      s_axi_awaddr,
   output logic                   s_axi_awvalid,
   input  wire logic              s_axi_awready,
   output logic [DATA_W-1:0]      s_axi_wdata,
   output logic [3:0]             s_axi_wstrb,
   output logic                   s_axi_wvalid,
   input  wire logic              s_axi_wready,
   input  wire logic [1:0]        s_axi_bresp,
   input  wire logic              s_axi_bvalid,
   output logic                   s_axi_bready,
   output logic [ADDR_W-1:0]      s_axi_araddr,
   output logic                   s_axi_arvalid,
   input  wire logic              s_axi_arready,
   input  wire logic [DATA_W-1:0] s_axi_rdata,
   input  wire logic [1:0]        s_axi_rresp,
   input  wire logic              s_axi_rvalid,
   output logic                   s_axi_rready
);
   // ready for answers at all times, so no release races between transfers
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
      s_axi_wstrb <= 4'hF;
      s_axi_bready <= 1'b1;
      s_axi_rready <= 1'b1;
   end

   task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d, output logic [1:0] r);
      bit a;
      bit w;
      a = 0;
      w = 0;
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(a && w)) begin
         @(posedge mclk);
         if (!a && s_axi_awready) begin
            a = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge mclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask

   task automatic rd(input logic [IDX_W-1:0] i, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
endmodule

// file: verif/lus_regs_assertions.sv
`timescale 1ns/10ps
module lus_regs_assertions
   import lus_pkg::*;
(
   // clock and reset
   input wire logic      mclk,
   input wire logic      sys_rst,
   // bus handshakes
   input wire logic      s_axi_awvalid,
   input wire logic      s_axi_awready,
   input wire logic      s_axi_wvalid,
   input wire logic      s_axi_wready,
   input wire logic      s_axi_bvalid,
   input wire logic      s_axi_bready,
   input wire logic      s_axi_arvalid,
   input wire logic      s_axi_arready,
   input wire logic      s_axi_rvalid,
   input wire logic      s_axi_rready,
   // line side
   input wire lus_line_t lineIn,
   input wire lus_evt_t  evtIn,
   input wire lus_term_t txTerm,
   input wire lus_term_t rxTerm,
   input wire logic      irq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   property p_b_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("write response missing");
   property p_b_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_done: assert property (p_b_done) else $error("write response repeated");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read response missing");
   property p_r_done;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_done: assert property (p_r_done) else $error("read response repeated");
   property p_w_refuse;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_w_refuse: assert property (p_w_refuse) else $error("write taken during response");
   // a drop of irq needs a register write right before it
   property p_irq_fall;
      $fell(irq) |-> $past(s_axi_bvalid);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
   // event pulse sets status one edge later, irq one more
   property p_irq_rise;
      $rose(irq) |-> $past(s_axi_bvalid) || $past(evtIn, 2) != '0
         || $past(lineIn, 2) != $past(lineIn, 3);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
   // outputs follow the register one edge after the write lands
   property p_term_hold;
      !$stable({txTerm, rxTerm}) |-> $past(s_axi_bvalid) || $past(sys_rst) || $past(sys_rst, 2);
   endproperty
   a_term_hold: assert property (p_term_hold) else $error("termination moved");
endmodule

bind lus_regs lus_regs_assertions u_chk (.*);

// file: verif/testbench.sv
`timescale 1ns/10ps
module testbench
   import lus_pkg::*;
;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic              s_axi_rvalid, s_axi_rready, mclk, sys_rst, irq;
   lus_line_t         lineIn;
   lus_evt_t          evtIn;
   lus_term_t         txTerm, rxTerm;
   logic [15:0]       excessZerosCount;
   logic [4:0]        equalizerGainCode;
   logic [6:0]        txPointerDistance, rxPointerDistance;
   logic [31:0]       d;
   logic [1:0]        r;
   int                nErrors, checkCount, mStatL, mEnL, mStatE, mEnE;
   int unsigned       seed = 20;

   lus_regs #(.REPORT_PERIOD_CYCLES(20)) dut (.*);
   lus_host u_host (.*);

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   ////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checkCount++;
      if (g !== e) begin
         nErrors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rdc(input logic [IDX_W-1:0] i, input logic [7:0] e);
      u_host.rd(i, d, r);
      chk("rdata", {24'h00_0000, e}, d);
      chk("rresp", 32'(RESP_OKAY), 32'(r));
   endtask

   task automatic wrc(input logic [IDX_W-1:0] i, input logic [7:0] v);
      u_host.wr(i, v, r);
      chk("bresp", 32'(RESP_OKAY), 32'(r));
   endtask

   // model of the interrupt pin from shadowed status and enables
   task automatic cirq();
      repeat (3) @(posedge mclk);
      chk("irq", 32'(((mStatL & mEnL) | (mStatE & mEnE)) != 0), 32'(irq));
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      nErrors++;
      tally_and_finish();
   end
   ////////////////////////////////////////
   initial begin
      sys_rst <= 1'b1;
      lineIn <= '0;
      evtIn <= '0;
      {excessZerosCount, equalizerGainCode, txPointerDistance, rxPointerDistance} <= '0;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rdc(IDX_TERM_SEL, RESET_TERM);
      for (int c = 0; c < 8; c++) begin
         wrc(IDX_TERM_SEL, {2'b00, 3'(c), ~3'(c)});
         // decoded outputs settle one edge after the register
         @(posedge mclk);
         chk("txTerm", 32'(c), 32'(txTerm));
         chk("rxTerm", 32'(7 - c), 32'(rxTerm));
      end
      u_host.rd(10'h3FF, d, r);
      chk("unmapped rresp", 32'(RESP_SLVERR), {30'h0, r});
      u_host.wr(10'h3FF, 8'hFF, r);
      chk("unmapped bresp", 32'(RESP_SLVERR), {30'h0, r});
      repeat (3) begin
         lineIn <= lus_line_t'(rnd());
         equalizerGainCode <= 5'(rnd());
         txPointerDistance <= 7'(rnd());
         rxPointerDistance <= 7'(rnd());
         repeat (2) @(posedge mclk);
         rdc(IDX_LINE_COND, {5'h0, lineIn.driverFail, 1'b0, lineIn.signalAbsent});
         rdc(IDX_EQ_GAIN, {3'h0, equalizerGainCode});
         rdc(IDX_TX_SPREAD, {1'b0, txPointerDistance});
         rdc(IDX_RX_SPREAD, {1'b0, rxPointerDistance});
      end
      // snapshot: held trigger must not copy again
      excessZerosCount <= 16'h5AC3;
      wrc(IDX_CNT_CTRL, 8'h01);
      excessZerosCount <= 16'h1234;
      wrc(IDX_CNT_CTRL, 8'h01);
      repeat (25) @(posedge mclk);
      rdc(IDX_CNT_HIGH, 8'h5A);
      rdc(IDX_CNT_LOW, 8'hC3);
      wrc(IDX_CNT_CTRL, 8'h00);
      wrc(IDX_CNT_CTRL, 8'h01);
      repeat (2) @(posedge mclk);
      rdc(IDX_CNT_LOW, 8'h34);
      excessZerosCount <= 16'(rnd());
      wrc(IDX_CNT_CTRL, 8'h02);
      repeat (25) @(posedge mclk);
      rdc(IDX_CNT_HIGH, excessZerosCount[15:8]);
      // peak spread window, then clear
      wrc(IDX_TX_PEAK_CTRL, 8'h20);
      txPointerDistance <= 7'd10;
      repeat (2) @(posedge mclk);
      u_host.rd(IDX_TX_SPREAD, d, r);
      txPointerDistance <= 7'd40;
      repeat (2) @(posedge mclk);
      txPointerDistance <= 7'd20;
      repeat (2) @(posedge mclk);
      rdc(IDX_TX_SPREAD, 8'd30);
      txPointerDistance <= 7'd50;
      repeat (2) @(posedge mclk);
      wrc(IDX_TX_SPREAD, 8'h01);
      rdc(IDX_TX_SPREAD, 8'd0);
      // interrupts: error sources one by one
      lineIn <= '0;
      repeat (3) @(posedge mclk);
      wrc(IDX_IRQ_CLR_LINE, MASK_LINE);
      for (int k = 0; k < 8; k++) begin
         if (MASK_ERR[k]) begin
            mEnE = MASK_ERR & ~(1 << k);
            wrc(IDX_IRQ_EN_ERR, 8'(mEnE));
            evtIn <= lus_evt_t'(6'(1 << (k > 3 ? k - 1 : k)));
            @(posedge mclk);
            evtIn <= '0;
            mStatE = 1 << k;
            cirq();
            rdc(IDX_IRQ_STAT_ERR, 8'(mStatE));
            mEnE = 1 << k;
            wrc(IDX_IRQ_EN_ERR, 8'(mEnE));
            cirq();
            wrc(k[0] ? IDX_IRQ_STAT_ERR : IDX_IRQ_CLR_ERR, 8'(mStatE));
            mStatE = 0;
            cirq();
         end
      end
      // line sources: absent on rising only, driver fail on both edges
      mEnL = 5;
      wrc(IDX_IRQ_EN_LINE, 8'h05);
      wrc(IDX_EDGE_SEL, 8'h04);
      lineIn <= lus_line_t'(2'b01);
      mStatL = 1;
      cirq();
      rdc(IDX_IRQ_STAT_LINE, 8'h01);
      wrc(IDX_IRQ_CLR_LINE, 8'h01);
      // driver fail rises and sets; absent falls and must not
      lineIn <= lus_line_t'(2'b10);
      mStatL = 4;
      cirq();
      rdc(IDX_IRQ_STAT_LINE, 8'h04);
      wrc(IDX_IRQ_CLR_LINE, 8'h04);
      lineIn <= '0;
      mStatL = 4;
      cirq();
      mEnL = 0;
      wrc(IDX_IRQ_EN_LINE, 8'h00);
      cirq();
      tally_and_finish();
   end
endmodule
